// [hw/rxpc_pkg.sv]
// Package with register map, field layouts, reset values and timing for the rx port config block.
// Function
// RULE1: Write auto-acknowledge bit makes every write to remote target seven acknowledged.
// RULE2: Incoming address matching alias bits 7:1 is replaced by the physical address.
// RULE3: Alias value zero disables decoding and forwarding for that remote target.
// RULE4: Physical replacement address is a separately held seven-bit value.
// RULE5: Cable bit 2: zero twisted pair, one coax; strap-loaded, then writable.
// RULE6: Format field 01 low-freq twelve, 10 high-freq twelve, 11 ten-bit; strap-loaded.
// RULE7: Slot selector codes pick GPIO 0-3, constant 0, constant 1 or frame marker.
// RULE8: Every slot selector resets to 0x8, sending constant zero.
// RULE9: Clock steady only while each measurement stays within tolerance of previous; reset 0x3.
// RULE10: Settle field picks 40 us, 80 us, 320 us or 1.28 ms before steady.
// RULE11: Absent flag set while measured frequency is below floor; floor resets to 0x5.
// RULE12: Two scratch registers are plain storage, resetting to zero and 0x01.
package rxpc_pkg;

  localparam logic [7:0] ADDR_ALIAS7    = 8'h6c;
  localparam logic [7:0] ADDR_PHYS7     = 8'h64;
  localparam logic [7:0] ADDR_PORT_CFG  = 8'h6d;
  localparam logic [7:0] ADDR_BC_LOW    = 8'h6e;
  localparam logic [7:0] ADDR_BC_HIGH   = 8'h6f;
  localparam logic [7:0] ADDR_FREQ_CTL  = 8'h77;
  localparam logic [7:0] ADDR_SCRATCH_A = 8'h78;
  localparam logic [7:0] ADDR_SCRATCH_B = 8'h79;

  localparam logic [7:0] RST_ALIAS      = 8'h00;
  localparam logic [7:0] RST_PHYS       = 8'h00;
  localparam logic [4:0] RST_PORT_RSVD  = 5'h0f;
  localparam logic [3:0] RST_SLOT_SEL   = 4'h8;
  localparam logic [1:0] RST_TOLERANCE  = 2'h3;
  localparam logic [1:0] RST_SETTLE     = 2'h0;
  localparam logic [3:0] RST_FLOOR      = 4'h5;
  localparam logic [7:0] RST_SCRATCH_A  = 8'h00;
  localparam logic [7:0] RST_SCRATCH_B  = 8'h01;

  localparam int         COAX_BIT       = 2;
  localparam logic [6:0] ALIAS_OFF      = 7'h00;

  localparam logic [3:0] SEL_GPIO_MAX   = 4'h3;
  localparam logic [3:0] SEL_CONST0     = 4'h8;
  localparam logic [3:0] SEL_CONST1     = 4'h9;
  localparam logic [3:0] SEL_FRAME      = 4'ha;

  localparam int CLK_MHZ        = 100;
  localparam int SETTLE0_NS     = 40000;
  localparam int SETTLE1_NS     = 80000;
  localparam int SETTLE2_NS     = 320000;
  localparam int SETTLE3_NS     = 1280000;
  localparam int CLK_PERIOD_NS  = 1000 / CLK_MHZ;
  localparam int SETTLE0_CYC    = SETTLE0_NS / CLK_PERIOD_NS;
  localparam int SETTLE1_CYC    = SETTLE1_NS / CLK_PERIOD_NS;
  localparam int SETTLE2_CYC    = SETTLE2_NS / CLK_PERIOD_NS;
  localparam int SETTLE3_CYC    = SETTLE3_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RXPC_FMT_RSVD = 2'b00,
    RXPC_FMT_LF12 = 2'b01,
    RXPC_FMT_HF12 = 2'b10,
    RXPC_FMT_T10  = 2'b11
  } rxpc_format_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rxpc_reg_req_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       valid;
    logic       is_write;
  } rxpc_i2c_req_t;

endpackage

// [hw/rxpc_settle_timer.sv]
// Settle timer that raises the steady flag after a qualified dwell time.
`timescale 1ns/1ps
module rxpc_settle_timer #(
  parameter int CNT_W = 18
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             restart_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic                  done_o
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count  <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (restart_i) begin
        count  <= '0;
        done_o <= 1'b0;
      end else if (count >= limit_i) begin
        done_o <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule

// [hw/rxpc_port_regs.sv]
// Per-port receive configuration registers with alias match, routing and clock detector.
`timescale 1ns/1ps
module rxpc_port_regs #(
  parameter int SETTLE3_CYCLES = rxpc_pkg::SETTLE3_CYC,
  parameter int FREQ_W         = 8
) (
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RST_I,
  input  wire logic                  CE_I,
  input  wire rxpc_pkg::rxpc_reg_req_t REG_REQ_I,
  output logic [7:0]                 REG_RDATA_O,
  output logic                       REG_ACK_O,
  input  wire logic                  STRAP_LOAD_I,
  input  wire logic [2:0]            STRAP_MODE_I,
  input  wire rxpc_pkg::rxpc_i2c_req_t I2C_REQ_I,
  output logic                       I2C_MATCH_O,
  output logic [6:0]                 I2C_FWD_ADDR_O,
  output logic                       I2C_AUTO_ACK_O,
  input  wire logic [3:0]            GPIO_PIN_I,
  input  wire logic                  FRAME_MARKER_I,
  output logic [3:0]                 BC_SLOT_O,
  input  wire logic                  FREQ_VALID_I,
  input  wire logic [FREQ_W-1:0]     FREQ_MHZ_I,
  output logic                       CLK_STEADY_O,
  output logic                       CLK_ABSENT_O,
  output logic                       COAX_MODE_O,
  output logic [1:0]                 INPUT_FORMAT_O
);

  //////////////////////////////////////////////////////////////////////////////

  logic [6:0] target_alias_address;
  logic       auto_ack;
  logic [6:0] phys_address;
  logic [4:0] port_rsvd;
  logic       coax;
  logic [1:0] input_format_select;
  logic [3:0] back_channel_slot0_source;
  logic [3:0] back_channel_slot1_source;
  logic [3:0] back_channel_slot2_source;
  logic [3:0] back_channel_slot3_source;
  logic [1:0] clock_freq_tolerance;
  logic [1:0] clock_freq_settle_time;
  logic [3:0] clock_freq_floor;
  logic [7:0] scratch_a;
  logic [7:0] scratch_b;
  logic [7:0] next_rdata;
  logic       wr;

  assign wr = REG_REQ_I.wr;

  // Reserved selector codes fall through to zero, the same as the constant-zero code.
  function automatic logic slot_value(input logic [3:0] sel, input logic [3:0] pins,
                                      input logic frame);
    if (sel <= rxpc_pkg::SEL_GPIO_MAX) begin
      slot_value = pins[sel[1:0]];
    end else if (sel == rxpc_pkg::SEL_CONST1) begin
      slot_value = 1'b1;
    end else if (sel == rxpc_pkg::SEL_FRAME) begin
      slot_value = frame;
    end else begin
      slot_value = 1'b0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // The physical address sits in its own slot at 0x64, eight below the alias register at 0x6c.
  // RULE2 RULE4 alias registers.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      target_alias_address <= rxpc_pkg::RST_ALIAS[7:1];
      auto_ack             <= rxpc_pkg::RST_ALIAS[0];
      phys_address         <= rxpc_pkg::RST_PHYS[7:1];
    end else if (CE_I && wr) begin
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_ALIAS7) begin
        target_alias_address <= REG_REQ_I.wdata[7:1];
        auto_ack             <= REG_REQ_I.wdata[0];
      end
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_PHYS7) begin
        phys_address <= REG_REQ_I.wdata[7:1];
      end
    end
  end

  // RULE5 RULE6 strap load then writable.
  // The strap wins over a write in the same cycle so the pins define the power-up mode.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      port_rsvd           <= rxpc_pkg::RST_PORT_RSVD;
      coax                <= 1'b0;
      input_format_select <= rxpc_pkg::RXPC_FMT_RSVD;
    end else if (CE_I) begin
      if (STRAP_LOAD_I) begin
        coax                <= STRAP_MODE_I[rxpc_pkg::COAX_BIT];
        input_format_select <= STRAP_MODE_I[1:0];
      end else if (wr && REG_REQ_I.addr == rxpc_pkg::ADDR_PORT_CFG) begin
        port_rsvd           <= REG_REQ_I.wdata[7:3];
        coax                <= REG_REQ_I.wdata[rxpc_pkg::COAX_BIT];
        input_format_select <= REG_REQ_I.wdata[1:0];
      end
    end
  end

  // RULE8 selectors reset to constant zero.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      back_channel_slot0_source <= rxpc_pkg::RST_SLOT_SEL;
      back_channel_slot1_source <= rxpc_pkg::RST_SLOT_SEL;
      back_channel_slot2_source <= rxpc_pkg::RST_SLOT_SEL;
      back_channel_slot3_source <= rxpc_pkg::RST_SLOT_SEL;
    end else if (CE_I && wr) begin
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_BC_LOW) begin
        back_channel_slot1_source <= REG_REQ_I.wdata[7:4];
        back_channel_slot0_source <= REG_REQ_I.wdata[3:0];
      end
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_BC_HIGH) begin
        back_channel_slot3_source <= REG_REQ_I.wdata[7:4];
        back_channel_slot2_source <= REG_REQ_I.wdata[3:0];
      end
    end
  end

  // RULE9 RULE11 detector settings reset values.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clock_freq_tolerance   <= rxpc_pkg::RST_TOLERANCE;
      clock_freq_settle_time <= rxpc_pkg::RST_SETTLE;
      clock_freq_floor       <= rxpc_pkg::RST_FLOOR;
    end else if (CE_I && wr && REG_REQ_I.addr == rxpc_pkg::ADDR_FREQ_CTL) begin
      clock_freq_tolerance   <= REG_REQ_I.wdata[7:6];
      clock_freq_settle_time <= REG_REQ_I.wdata[5:4];
      clock_freq_floor       <= REG_REQ_I.wdata[3:0];
    end
  end

  // Reads never alter the scratch contents, so hosts on both ends may poll freely.
  // RULE12 plain scratch storage.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scratch_a <= rxpc_pkg::RST_SCRATCH_A;
      scratch_b <= rxpc_pkg::RST_SCRATCH_B;
    end else if (CE_I && wr) begin
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_SCRATCH_A) begin
        scratch_a <= REG_REQ_I.wdata;
      end
      if (REG_REQ_I.addr == rxpc_pkg::ADDR_SCRATCH_B) begin
        scratch_b <= REG_REQ_I.wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Unmapped offsets read as zero but are still acknowledged, so a host never stalls.
  always_comb begin
    case (REG_REQ_I.addr)
      rxpc_pkg::ADDR_ALIAS7:    next_rdata = {target_alias_address, auto_ack};
      rxpc_pkg::ADDR_PHYS7:     next_rdata = {phys_address, 1'b0};
      rxpc_pkg::ADDR_PORT_CFG:  next_rdata = {port_rsvd, coax, input_format_select};
      rxpc_pkg::ADDR_BC_LOW:    next_rdata = {back_channel_slot1_source,
                                              back_channel_slot0_source};
      rxpc_pkg::ADDR_BC_HIGH:   next_rdata = {back_channel_slot3_source,
                                              back_channel_slot2_source};
      rxpc_pkg::ADDR_FREQ_CTL:  next_rdata = {clock_freq_tolerance, clock_freq_settle_time,
                                              clock_freq_floor};
      rxpc_pkg::ADDR_SCRATCH_A: next_rdata = scratch_a;
      rxpc_pkg::ADDR_SCRATCH_B: next_rdata = scratch_b;
      default:                  next_rdata = 8'h00;
    endcase
  end

  // Read data holds until the next read, so a slow host may collect it late.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
      REG_ACK_O   <= 1'b0;
    end else if (CE_I) begin
      REG_ACK_O <= REG_REQ_I.wr | REG_REQ_I.rd;
      if (REG_REQ_I.rd) begin
        REG_RDATA_O <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Remapping is registered so the forwarded address is glitch free for the channel logic.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      I2C_MATCH_O    <= 1'b0;
      I2C_FWD_ADDR_O <= 7'h00;
      I2C_AUTO_ACK_O <= 1'b0;
    end else if (CE_I) begin
      // RULE3 zero alias disables.
      if (I2C_REQ_I.valid && target_alias_address != rxpc_pkg::ALIAS_OFF &&
          I2C_REQ_I.addr == target_alias_address) begin
        // RULE2 substitute physical address.
        I2C_MATCH_O    <= 1'b1;
        I2C_FWD_ADDR_O <= phys_address;
        // RULE1 auto-acknowledge writes.
        I2C_AUTO_ACK_O <= auto_ack & I2C_REQ_I.is_write;
      end else begin
        I2C_MATCH_O    <= 1'b0;
        I2C_FWD_ADDR_O <= I2C_REQ_I.addr;
        I2C_AUTO_ACK_O <= 1'b0;
      end
    end
  end

  // RULE7 back-channel slot sources.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BC_SLOT_O <= 4'h0;
    end else if (CE_I) begin
      BC_SLOT_O <= {slot_value(back_channel_slot3_source, GPIO_PIN_I, FRAME_MARKER_I),
                    slot_value(back_channel_slot2_source, GPIO_PIN_I, FRAME_MARKER_I),
                    slot_value(back_channel_slot1_source, GPIO_PIN_I, FRAME_MARKER_I),
                    slot_value(back_channel_slot0_source, GPIO_PIN_I, FRAME_MARKER_I)};
    end
  end

  // RULE5 RULE6 mode outputs.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      COAX_MODE_O    <= 1'b0;
      INPUT_FORMAT_O <= 2'b00;
    end else if (CE_I) begin
      COAX_MODE_O    <= coax;
      INPUT_FORMAT_O <= input_format_select;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // The dwell counter is sized for the longest settle time, so a short simulation value
  // still leaves room for the three fixed settings.
  localparam int SETTLE_MAX = (SETTLE3_CYCLES > rxpc_pkg::SETTLE2_CYC) ? SETTLE3_CYCLES
                                                                       : rxpc_pkg::SETTLE2_CYC;
  localparam int SETTLE_W   = $clog2(SETTLE_MAX + 1);

  logic [FREQ_W-1:0]   prev_freq;
  logic                have_prev;
  logic                out_of_tol;
  logic                restart;
  logic [SETTLE_W-1:0] settle_limit;
  logic                settle_done;
  logic [FREQ_W:0]     diff;

  // The first sample has nothing to compare against, so it only starts the dwell count.
  always_comb begin
    diff = (FREQ_MHZ_I >= prev_freq) ? {1'b0, FREQ_MHZ_I - prev_freq}
                                     : {1'b0, prev_freq - FREQ_MHZ_I};
    out_of_tol = diff > {{(FREQ_W - 1){1'b0}}, clock_freq_tolerance};
    restart = !have_prev || (FREQ_VALID_I && out_of_tol);
    case (clock_freq_settle_time)
      2'b00:   settle_limit = SETTLE_W'(rxpc_pkg::SETTLE0_CYC);
      2'b01:   settle_limit = SETTLE_W'(rxpc_pkg::SETTLE1_CYC);
      2'b10:   settle_limit = SETTLE_W'(rxpc_pkg::SETTLE2_CYC);
      default: settle_limit = SETTLE_W'(SETTLE3_CYCLES);
    endcase
  end

  // RULE9 compare against previous measurement.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prev_freq <= '0;
      have_prev <= 1'b0;
    end else if (CE_I && FREQ_VALID_I) begin
      prev_freq <= FREQ_MHZ_I;
      have_prev <= 1'b1;
    end
  end

  // A restart clears the count, so any step outside tolerance starts the dwell again.
  // RULE10 settle time before steady.
  rxpc_settle_timer #(
    .CNT_W (SETTLE_W)
  ) u_settle (
    .clk_i     (REF_CLK_I),
    .rst_i     (RST_I),
    .ce_i      (CE_I),
    .restart_i (restart),
    .limit_i   (settle_limit),
    .done_o    (settle_done)
  );

  // Steady is masked in the restart cycle itself, so it drops with no extra delay.
  // The absent flag only moves on a fresh sample, because the meter bus is not valid between.
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CLK_STEADY_O <= 1'b0;
      CLK_ABSENT_O <= 1'b1;
    end else if (CE_I) begin
      CLK_STEADY_O <= settle_done && !restart;
      // RULE11 below floor means absent.
      if (FREQ_VALID_I) begin
        CLK_ABSENT_O <= FREQ_MHZ_I < {{(FREQ_W - 4){1'b0}}, clock_freq_floor};
      end
    end
  end

endmodule

// [dv/rxpc_port_regs_monitor.sv]
// Concurrent checks on the ports of the rx port config block.
`timescale 1ns/1ps
module rxpc_port_regs_monitor #(
  parameter int SETTLE3_CYCLES = rxpc_pkg::SETTLE3_CYC,
  parameter int FREQ_W         = 8
) (
  input wire logic                    REF_CLK_I,
  input wire logic                    RST_I,
  input wire logic                    CE_I,
  input wire rxpc_pkg::rxpc_reg_req_t REG_REQ_I,
  input wire logic                    REG_ACK_O,
  input wire logic                    STRAP_LOAD_I,
  input wire logic [2:0]              STRAP_MODE_I,
  input wire rxpc_pkg::rxpc_i2c_req_t I2C_REQ_I,
  input wire logic                    I2C_MATCH_O,
  input wire logic [6:0]              I2C_FWD_ADDR_O,
  input wire logic                    I2C_AUTO_ACK_O,
  input wire logic                    FREQ_VALID_I,
  input wire logic [FREQ_W-1:0]       FREQ_MHZ_I,
  input wire logic                    CLK_STEADY_O,
  input wire logic                    CLK_ABSENT_O,
  input wire logic                    COAX_MODE_O,
  input wire logic [1:0]              INPUT_FORMAT_O
);
  localparam int MIN_SET = (SETTLE3_CYCLES < rxpc_pkg::SETTLE0_CYC) ? SETTLE3_CYCLES
                                                                     : rxpc_pkg::SETTLE0_CYC;
  logic [FREQ_W-1:0] prev;
  logic [FREQ_W-1:0] diff;
  logic              have_prev;
  logic              jump;
  int                quiet;
  ////////////////////////////////////////////////////////////////////////////////
  assign diff = (FREQ_MHZ_I > prev) ? FREQ_MHZ_I - prev : prev - FREQ_MHZ_I;
  // The tolerance field tops out at 3 MHz, so a larger step restarts for any setting.
  assign jump = !have_prev || (diff > FREQ_W'(3));
  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      prev <= '0;
      have_prev <= 1'b0;
      quiet <= 0;
    end else if (CE_I) begin
      quiet <= (FREQ_VALID_I && jump) ? 0 : ((quiet < MIN_SET) ? quiet + 1 : quiet);
      if (FREQ_VALID_I) begin
        prev <= FREQ_MHZ_I;
        have_prev <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  a_reg_ack_pulse: assert property (CE_I && (REG_REQ_I.wr || REG_REQ_I.rd) |=> REG_ACK_O)
    else $error("register access got no acknowledge");
  a_alias_zero_off: assert property ($past(CE_I) && I2C_MATCH_O |->
    $past(I2C_REQ_I.valid) && $past(I2C_REQ_I.addr) != 7'h00)
    else $error("match without a valid nonzero address");
  a_auto_ack_write: assert property ($past(CE_I) && I2C_AUTO_ACK_O |->
    I2C_MATCH_O && $past(I2C_REQ_I.is_write))
    else $error("auto acknowledge outside a matched write");
  a_fwd_passthru: assert property ($past(CE_I && I2C_REQ_I.valid) && !I2C_MATCH_O |->
    I2C_FWD_ADDR_O == $past(I2C_REQ_I.addr))
    else $error("unmatched address was altered");
  a_strap_load_copy: assert property ((CE_I && STRAP_LOAD_I && $stable(STRAP_MODE_I))[*3] |->
    COAX_MODE_O == STRAP_MODE_I[2] && INPUT_FORMAT_O == STRAP_MODE_I[1:0])
    else $error("strap not loaded into port config");
  a_absent_on_sample: assert property ($changed(CLK_ABSENT_O) |-> $past(CE_I && FREQ_VALID_I))
    else $error("absent flag moved without a sample");
  a_steady_dwell: assert property ($rose(CLK_STEADY_O) |-> quiet >= MIN_SET - 2)
    else $error("steady raised before the settle time");
  a_jump_drops: assert property (CE_I && FREQ_VALID_I && jump |-> ##[1:3] !CLK_STEADY_O)
    else $error("steady kept after an out of range step");
endmodule
bind rxpc_port_regs rxpc_port_regs_monitor #(.SETTLE3_CYCLES(SETTLE3_CYCLES), .FREQ_W(FREQ_W)) u_mon (
  .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .REG_REQ_I(REG_REQ_I), .REG_ACK_O(REG_ACK_O),
  .STRAP_LOAD_I(STRAP_LOAD_I), .STRAP_MODE_I(STRAP_MODE_I), .I2C_REQ_I(I2C_REQ_I),
  .I2C_MATCH_O(I2C_MATCH_O), .I2C_FWD_ADDR_O(I2C_FWD_ADDR_O), .I2C_AUTO_ACK_O(I2C_AUTO_ACK_O),
  .FREQ_VALID_I(FREQ_VALID_I), .FREQ_MHZ_I(FREQ_MHZ_I), .CLK_STEADY_O(CLK_STEADY_O),
  .CLK_ABSENT_O(CLK_ABSENT_O), .COAX_MODE_O(COAX_MODE_O), .INPUT_FORMAT_O(INPUT_FORMAT_O));

// [dv/rxpc_meas_model.sv]
// Remote link clock measurement source giving one frequency sample every sixteen cycles.
`timescale 1ns/1ps
module rxpc_meas_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] mhz_i,
  output logic            valid_o,
  output logic [7:0]      mhz_o
);
  logic [3:0] tick;
  logic [7:0] last;
  // Between samples the bus shows the inverse, so a stale capture is caught.
  assign mhz_o = valid_o ? last : ~last;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick <= 4'h0;
      valid_o <= 1'b0;
      last <= 8'h00;
    end else begin
      tick <= tick + 4'h1;
      valid_o <= run_i && (tick == 4'hf);
      if (tick == 4'hf) begin
        last <= mhz_i;
      end
    end
  end
endmodule

// [dv/tb_top.sv]
// Self-checking testbench for the rx port config register block.
`timescale 1ns/1ps
module tb_top;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    ce = 1'b1;
  logic                    ld = 1'b0;
  logic                    run = 1'b0;
  logic                    ack, match, aack, steady, absent, coax, fvalid;
  logic [2:0]              mode = 3'h5;
  logic [3:0]              slot;
  logic [1:0]              fmt;
  logic [6:0]              fwd;
  logic [7:0]              mhz = 8'h32;
  logic [7:0]              fmhz, rdata, got;
  rxpc_pkg::rxpc_reg_req_t req = '0;
  rxpc_pkg::rxpc_i2c_req_t ireq = '0;
  int                      failures = 0;
  int                      checks = 0;
  int                      n;
  logic [7:0] ra [8] = '{8'h6c, 8'h64, 8'h6d, 8'h6e, 8'h6f, 8'h77, 8'h78, 8'h79};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h78, 8'h88, 8'h88, 8'hc5, 8'h00, 8'h01};
  logic [3:0] code [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'h4, 4'hb};
  logic       cval [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  localparam int S3 = 200;
  int         settle [4] = '{rxpc_pkg::SETTLE0_CYC, rxpc_pkg::SETTLE1_CYC,
                             rxpc_pkg::SETTLE2_CYC, S3};
  logic [3:0] gpio = 4'h5;
  logic       frm = 1'b1;
  always #5 clk = ~clk;
  rxpc_port_regs #(.SETTLE3_CYCLES(S3)) DUT (.REF_CLK_I(clk), .RST_I(rst), .CE_I(ce),
    .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_ACK_O(ack), .STRAP_LOAD_I(ld),
    .STRAP_MODE_I(mode), .I2C_REQ_I(ireq), .I2C_MATCH_O(match), .I2C_FWD_ADDR_O(fwd),
    .I2C_AUTO_ACK_O(aack), .GPIO_PIN_I(gpio), .FRAME_MARKER_I(frm), .BC_SLOT_O(slot),
    .FREQ_VALID_I(fvalid), .FREQ_MHZ_I(fmhz), .CLK_STEADY_O(steady), .CLK_ABSENT_O(absent),
    .COAX_MODE_O(coax), .INPUT_FORMAT_O(fmt));
  rxpc_meas_model u_far (.clk_i(clk), .rst_i(rst), .run_i(run), .mhz_i(mhz), .valid_o(fvalid),
    .mhz_o(fmhz));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // An idle cycle follows every access, so the strobes never change twice in one step.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
    got = rdata;
    check(ack, ce);
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    check(got, e);
  endtask
  task automatic i2c(input logic [6:0] a, input logic w, input logic m, input logic [6:0] f,
                     input logic k);
    ireq = '{addr: a, valid: 1'b1, is_write: w};
    @(posedge clk);
    #1;
    check(match, m);
    check(fwd, f);
    check(aack, k);
    ireq.valid = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_for(ref logic s, input logic e, input int lim);
    n = 0;
    while (s !== e && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (s !== e) begin
      check(s, e);
      results();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    check(absent, 1'b1);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    check(slot, 4'h0);
    acc(1'b1, 8'h70, 8'hff);
    rd(8'h70, 8'h00);
    rd(8'h7a, 8'h00);
    acc(1'b1, 8'h78, 8'h5a);
    acc(1'b1, 8'h79, 8'ha5);
    rd(8'h78, 8'h5a);
    rd(8'h79, 8'ha5);
    ce = 1'b0;
    acc(1'b1, 8'h78, 8'hff);
    ce = 1'b1;
    rd(8'h78, 8'h5a);
    acc(1'b1, 8'h64, 8'ha0);
    acc(1'b1, 8'h6c, 8'h43);
    i2c(7'h21, 1'b1, 1'b1, 7'h50, 1'b1);
    i2c(7'h21, 1'b0, 1'b1, 7'h50, 1'b0);
    i2c(7'h22, 1'b1, 1'b0, 7'h22, 1'b0);
    acc(1'b1, 8'h6c, 8'h01);
    i2c(7'h00, 1'b1, 1'b0, 7'h00, 1'b0);
    ld = 1'b1;
    repeat (3) @(posedge clk);
    #1 ld = 1'b0;
    check(coax, 1'b1);
    check(fmt, 2'h1);
    rd(8'h6d, 8'h7d);
    for (int f = 1; f < 4; f++) begin
      acc(1'b1, 8'h6d, {5'h0f, f[0], f[1:0]});
      @(posedge clk);
      #1;
      check(coax, f[0]);
      check(fmt, f[1:0]);
    end
    for (int i = 0; i < 9; i++) begin
      acc(1'b1, 8'h6e, {code[(i + 1) % 9], code[i]});
      acc(1'b1, 8'h6f, {code[(i + 3) % 9], code[(i + 2) % 9]});
      check(slot, {cval[(i + 3) % 9], cval[(i + 2) % 9], cval[(i + 1) % 9], cval[i]});
    end
    gpio = 4'ha;
    frm = 1'b0;
    acc(1'b1, 8'h6e, 8'h10);
    acc(1'b1, 8'h6f, 8'ha2);
    check(slot, 4'h2);
    run = 1'b1;
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, 8'h77, {2'b01, s[1:0], 4'h5});
      mhz = mhz ^ 8'h0f;
      wait_for(steady, 1'b0, 40);
      wait_for(steady, 1'b1, 40000);
      check(n >= settle[s] - 4 && n <= settle[s] + 40, 1'b1);
    end
    check(absent, 1'b0);
    mhz = mhz + 8'h01;
    wait_for(fvalid, 1'b1, 40);
    wait_for(fvalid, 1'b0, 4);
    wait_for(fvalid, 1'b1, 40);
    check(steady, 1'b1);
    mhz = mhz + 8'h02;
    wait_for(steady, 1'b0, 40);
    mhz = 8'h04;
    wait_for(absent, 1'b1, 40);
    mhz = 8'h05;
    wait_for(absent, 1'b0, 40);
    results();
  end
endmodule
